// *** sgc_cfg.svh ***
`ifndef SGC_CFG_SVH
`define SGC_CFG_SVH

// register byte offsets in short i/o space
`define SGC_OFS_MAIN 8'h04
`define SGC_OFS_TIMING 8'h05
`define SGC_OFS_RUN_HI 8'h06
`define SGC_OFS_RUN_LO 8'h07

// main command bit positions
`define SGC_B_MASTER 7
`define SGC_B_SLVDEC 6
`define SGC_B_WIDE 5
`define SGC_B_PRIV 4
`define SGC_B_BRK 3
`define SGC_B_TEST 2
`define SGC_B_RESTART 1
`define SGC_B_LEDOFF 0

// bus timing control fields
`define SGC_B_ARB 3
`define SGC_TO_MSB 2
`define SGC_TO_INFINITE 3'h7

// reset values
`define SGC_MAIN_RST 8'h00
`define SGC_TIMING_RST 8'h00
`define SGC_RUN_RST 16'h0000
`define SGC_RD_NONE 8'h00

// address modifiers for data accesses
`define SGC_AM_A32_SUP 6'h0d
`define SGC_AM_A32_USR 6'h09
`define SGC_AM_A24_SUP 6'h3d
`define SGC_AM_A24_USR 6'h39
`define SGC_A24_TOP 23

// buffer slot sizes: 32 kbyte in master mode, 1/64 of ram in slave mode
`define SGC_MASTER_SLOT_AW 15
`define SGC_SLAVE_SLOT_DIV_AW 6

// self-test selection
`define SGC_POR_TESTS 8'hff
`define SGC_SHAKE_TEST 7

// timing
`define SGC_CLK_PERIOD_NS 25
`define SGC_US_NS 1000
`define SGC_MS_NS 1000000
`define SGC_FLASH_NS 100000000
`define SGC_US_CYCLES (`SGC_US_NS / `SGC_CLK_PERIOD_NS)
`define SGC_MS_CYCLES (`SGC_MS_NS / `SGC_CLK_PERIOD_NS)
`define SGC_FLASH_CYCLES (`SGC_FLASH_NS / `SGC_CLK_PERIOD_NS)

// bus error timeouts in microseconds
`define SGC_TO_US_0 10'h004
`define SGC_TO_US_1 10'h010
`define SGC_TO_US_2 10'h020
`define SGC_TO_US_3 10'h040
`define SGC_TO_US_4 10'h080
`define SGC_TO_US_5 10'h100
`define SGC_TO_US_6 10'h200
`define SGC_TO_US_NOTSC 10'h032

`endif

// *** sgc_pkg.sv ***
package sgc_pkg;
  typedef enum logic [1:0] {BRK_IDLE, BRK_SCAN, BRK_HOLD} sgc_brk_state_t;
  typedef enum logic [1:0] {TST_IDLE, TST_ISSUE, TST_WAIT} sgc_tst_state_t;
endpackage

// *** sgc_tmr_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface sgc_tmr_if;
  logic [2:0] timeoutCode;
  logic sysCtrl;
  logic cycleActive;
  logic ackSeen;
  logic busError;
  modport ctrl (output timeoutCode, output sysCtrl, output cycleActive, output ackSeen,
    input busError);
  modport timer (input timeoutCode, input sysCtrl, input cycleActive, input ackSeen,
    output busError);
endinterface
`default_nettype wire

// *** sgc_bus_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sgc_cfg.svh"
module sgc_bus_timer (
  input wire logic ref_clk,
  input wire logic reset,
  sgc_tmr_if.timer tmr
);
  localparam int US_CYCLES = `SGC_US_CYCLES;
  localparam int PW = $clog2(US_CYCLES);

  logic [PW-1:0] preDiv_reg;
  logic [9:0] usCount_reg;
  logic [9:0] limitUs;
  logic usTick;
  logic busError_reg;

  assign usTick = (preDiv_reg == PW'(US_CYCLES - 1));
  assign tmr.busError = busError_reg;

  // limit in microseconds; non-controller uses one nominal value
  always_comb begin
    if (!tmr.sysCtrl) begin
      limitUs = `SGC_TO_US_NOTSC; // R16
    end else begin
      case (tmr.timeoutCode) // R15
        3'h0: limitUs = `SGC_TO_US_0;
        3'h1: limitUs = `SGC_TO_US_1;
        3'h2: limitUs = `SGC_TO_US_2;
        3'h3: limitUs = `SGC_TO_US_3;
        3'h4: limitUs = `SGC_TO_US_4;
        3'h5: limitUs = `SGC_TO_US_5;
        3'h6: limitUs = `SGC_TO_US_6;
        default: limitUs = `SGC_TO_US_0;
      endcase
    end
  end

  // microsecond prescaler, restarted with each bus cycle
  always_ff @(posedge ref_clk) begin
    if (reset || !tmr.cycleActive) begin
      preDiv_reg <= '0;
    end else if (usTick) begin
      preDiv_reg <= '0;
    end else begin
      preDiv_reg <= preDiv_reg + 1'b1;
    end
  end

  // elapsed microseconds, saturating at the limit
  always_ff @(posedge ref_clk) begin
    if (reset || !tmr.cycleActive) begin
      usCount_reg <= '0;
    end else if (usTick && usCount_reg != limitUs) begin
      usCount_reg <= usCount_reg + 1'b1;
    end
  end

  // bus error held until the cycle ends; code 111 never times out
  always_ff @(posedge ref_clk) begin
    if (reset || !tmr.cycleActive) begin
      busError_reg <= 1'b0;
    end else if (tmr.timeoutCode != `SGC_TO_INFINITE && !tmr.ackSeen
        && usCount_reg == limitUs) begin
      busError_reg <= 1'b1; // R15 R16
    end
  end
endmodule
`default_nettype wire

// *** sgc_global_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sgc_cfg.svh"
// Behaviour
// (R1) master bit one: buffers in external memory at buffer base; zero: on-board
// (R2) each buffer slot fixed: 1/64 of ram in slave, 32 kbyte in master
// (R3) slots ordered ch0 in, ch0 out, ... ending with ch15 out
// (R4) slave decode bit enables buffer access; its rise captures the window base
// (R5) host sets slave decode in slave mode, clears it in master mode
// (R6) wide bit decodes A32; otherwise A24 and base top byte ignored
// (R7) privileged-only bit restricts buffer access; never affects short i/o
// (R8) break launch rise sends breaks on active requested channels, then self-clears
// (R9) test launch rise runs selected tests msb first, stops on fail, self-clears
// (R10) busy reads one during test; pass leaves error and fail flags zero
// (R11) restart write reruns power-on tests except ram shake, absent meanwhile
// (R12) led off when indicator bit one; flashes during power-on tests
// (R13) host writes zeros to upper four timing bits
// (R14) arbiter scheme bit acts only as slot-1 controller with jumper fitted
// (R15) controller: bus error after selected timeout code, 111 never
// (R16) non-controller: nominal 50 us on own accesses unless code 111
// (R17) run enable starts channel; clearing it stops channel activity
// (R18) run enable bit n belongs to channel n
// (R19) setting run enable clears channel transmit request and receive accept
// (R20) host changes run enables only by indivisible read-modify-write
// (R21) break is spacing level lasting channel break length in ms
// (R22) break request bit clears when its break begins
// (R23) launch bit writes ignored while its operation runs; bit stays one
module sgc_global_regs #(
  parameter int NUM_CH = 16,
  parameter int TEST_W = 8,
  parameter int TIW = $clog2(TEST_W),
  parameter int RAM_AW = 17,
  parameter int unsigned MS_CYCLES = `SGC_MS_CYCLES,
  parameter int unsigned FLASH_CYCLES = `SGC_FLASH_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic regSelect,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  output logic [7:0] regReadData,
  output logic regAck,
  input wire logic [31:0] bufferBaseAddress,
  input wire logic [TEST_W-1:0] testProcedureSelect,
  output logic testStart,
  output logic [TIW-1:0] testIndex,
  input wire logic testDone,
  input wire logic testPass,
  input wire logic [NUM_CH-1:0] breakRequest,
  output logic [NUM_CH-1:0] breakRequestClear,
  input wire logic [NUM_CH*8-1:0] breakLengthsMs,
  output logic [NUM_CH-1:0] breakSpacing,
  output logic [NUM_CH-1:0] txRequestClear,
  output logic [NUM_CH-1:0] rxAcceptClear,
  output logic [NUM_CH-1:0] channelRunEnables,
  input wire logic [31:0] vmeAddr,
  input wire logic [5:0] vmeAm,
  input wire logic vmeValid,
  output logic bufferSelect,
  output logic [31:0] slaveWindowBase,
  input wire logic [3:0] bufChannel,
  input wire logic bufOutputDir,
  output logic [31:0] bufAddress,
  output logic masterMode,
  input wire logic slot1Pin,
  input wire logic controllerJumperPin,
  input wire logic ackPin,
  input wire logic busCycleActive,
  output logic busError,
  output logic arbiterPrioritized,
  output logic boardPresent,
  output logic testInProgress,
  output logic anyErrorFlag,
  output logic testFailedFlag,
  output logic indicatorLedOn
);
  localparam int SLAVE_SHIFT = RAM_AW - `SGC_SLAVE_SLOT_DIV_AW;
  localparam int MSW = $clog2(MS_CYCLES);
  localparam int FLW = $clog2(FLASH_CYCLES);
  localparam logic [TEST_W-1:0] RESTART_TESTS =
    `SGC_POR_TESTS & ~(TEST_W'(1) << `SGC_SHAKE_TEST);

  logic [7:0] mainCmd_reg;
  logic [7:0] timingCtrl_reg;
  logic [NUM_CH-1:0] runEn_reg, runEn_next, goRise;
  logic [2:0] sync1_reg, sync2_reg;
  logic sysCtrl;
  logic wrMain, wrTiming, restartReq, brkLaunch, tstLaunch;
  logic slvDecPrev_reg;
  sgc_pkg::sgc_brk_state_t brkState_reg;
  logic [3:0] brkCh_reg;
  logic [7:0] msLeft_reg;
  logic [MSW-1:0] msDiv_reg;
  logic brkHit, brkAdvance, brkFinish, brkBusy;
  sgc_pkg::sgc_tst_state_t tstState_reg;
  logic [TEST_W-1:0] pending_reg;
  logic porRun_reg, tstBusy, tstFinish, tstFail;
  logic [FLW-1:0] flashDiv_reg;
  logic flash_reg;
  logic wideHit, stdHit, amOk;
  logic [4:0] slotIdx;

  sgc_tmr_if tmr();

  // highest selected test still pending
  function automatic logic [TIW-1:0] topTest(input logic [TEST_W-1:0] p);
    logic [TIW-1:0] idx;
    idx = '0;
    for (int i = 0; i < TEST_W; i++) begin
      if (p[i]) idx = TIW'(i);
    end
    return idx;
  endfunction

  // pins from the backplane go through two flops before use
  always_ff @(posedge ref_clk) begin
    sync1_reg <= {ackPin, controllerJumperPin, slot1Pin};
    sync2_reg <= sync1_reg;
  end
  assign sysCtrl = sync2_reg[0] & sync2_reg[1]; // R14

  // register strobes; the board ignores short i/o while absent
  assign wrMain = regSelect & regWrite & boardPresent & (regAddr == `SGC_OFS_MAIN);
  assign wrTiming = regSelect & regWrite & boardPresent & (regAddr == `SGC_OFS_TIMING);
  assign restartReq = wrMain & regWriteData[`SGC_B_RESTART]; // R11
  assign brkBusy = (brkState_reg != sgc_pkg::BRK_IDLE);
  assign tstBusy = (tstState_reg != sgc_pkg::TST_IDLE);
  assign brkLaunch = wrMain & regWriteData[`SGC_B_BRK] & ~mainCmd_reg[`SGC_B_BRK]
    & ~brkBusy; // R8 R23
  assign tstLaunch = wrMain & regWriteData[`SGC_B_TEST] & ~mainCmd_reg[`SGC_B_TEST]
    & ~tstBusy; // R9 R23

  // main command byte; hardware owns the launch bits while they run
  always_ff @(posedge ref_clk) begin
    if (reset || restartReq) begin
      mainCmd_reg <= `SGC_MAIN_RST;
    end else begin
      if (wrMain) begin
        mainCmd_reg <= regWriteData;
        mainCmd_reg[`SGC_B_BRK] <= brkBusy | regWriteData[`SGC_B_BRK]; // R23
        mainCmd_reg[`SGC_B_TEST] <= tstBusy | regWriteData[`SGC_B_TEST]; // R23
      end
      if (brkFinish) mainCmd_reg[`SGC_B_BRK] <= 1'b0; // R8
      if (tstFinish) mainCmd_reg[`SGC_B_TEST] <= 1'b0; // R9
      if (tstFinish && porRun_reg && !tstFail) mainCmd_reg[`SGC_B_LEDOFF] <= 1'b1; // R12
    end
  end
  assign masterMode = mainCmd_reg[`SGC_B_MASTER];

  // bus timing byte; upper nibble stored as written
  always_ff @(posedge ref_clk) begin
    if (reset || restartReq) begin
      timingCtrl_reg <= `SGC_TIMING_RST;
    end else if (wrTiming) begin
      timingCtrl_reg <= regWriteData;
    end
  end

  // run enable word, two bytes, bit n is channel n
  always_comb begin
    runEn_next = runEn_reg;
    if (regSelect && regWrite && boardPresent && regAddr == `SGC_OFS_RUN_HI) begin
      runEn_next = NUM_CH'({regWriteData, 8'(runEn_reg)}); // R18
    end
    if (regSelect && regWrite && boardPresent && regAddr == `SGC_OFS_RUN_LO) begin
      runEn_next = NUM_CH'({8'(runEn_reg >> 8), regWriteData}); // R18
    end
  end
  assign goRise = runEn_next & ~runEn_reg;

  always_ff @(posedge ref_clk) begin
    if (reset || restartReq) begin
      runEn_reg <= NUM_CH'(`SGC_RUN_RST);
      txRequestClear <= '0;
      rxAcceptClear <= '0;
    end else begin
      runEn_reg <= runEn_next; // R17
      txRequestClear <= goRise; // R19
      rxAcceptClear <= goRise; // R19
    end
  end
  assign channelRunEnables = runEn_reg; // R17

  // read answer one cycle after select; no answer at all while absent
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      regAck <= 1'b0;
      regReadData <= `SGC_RD_NONE;
    end else begin
      regAck <= regSelect & boardPresent; // R11
      case (regAddr)
        `SGC_OFS_MAIN: regReadData <= mainCmd_reg;
        `SGC_OFS_TIMING: regReadData <= timingCtrl_reg;
        `SGC_OFS_RUN_HI: regReadData <= 8'(runEn_reg >> 8); // R18
        `SGC_OFS_RUN_LO: regReadData <= 8'(runEn_reg); // R18
        default: regReadData <= `SGC_RD_NONE;
      endcase
    end
  end

  // window base taken only on the enable's rise, so the base register may be reused
  always_ff @(posedge ref_clk) begin
    if (reset || restartReq) begin
      slvDecPrev_reg <= 1'b0;
      slaveWindowBase <= 32'h0000_0000;
    end else begin
      slvDecPrev_reg <= mainCmd_reg[`SGC_B_SLVDEC];
      if (mainCmd_reg[`SGC_B_SLVDEC] && !slvDecPrev_reg) begin
        slaveWindowBase <= bufferBaseAddress; // R4
      end
    end
  end

  // buffer memory decode; short i/o is decoded elsewhere without modifier checks
  assign wideHit = vmeAddr[31:RAM_AW] == slaveWindowBase[31:RAM_AW];
  assign stdHit = vmeAddr[`SGC_A24_TOP:RAM_AW] == slaveWindowBase[`SGC_A24_TOP:RAM_AW]; // R6
  always_comb begin
    if (mainCmd_reg[`SGC_B_WIDE]) begin
      amOk = (vmeAm == `SGC_AM_A32_SUP)
        || (!mainCmd_reg[`SGC_B_PRIV] && vmeAm == `SGC_AM_A32_USR); // R6 R7
    end else begin
      amOk = (vmeAm == `SGC_AM_A24_SUP)
        || (!mainCmd_reg[`SGC_B_PRIV] && vmeAm == `SGC_AM_A24_USR); // R6 R7
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bufferSelect <= 1'b0;
    end else begin
      bufferSelect <= vmeValid && mainCmd_reg[`SGC_B_SLVDEC] && amOk
        && (mainCmd_reg[`SGC_B_WIDE] ? wideHit : stdHit); // R4 R6
    end
  end

  // slot address: two slots per channel, input first
  assign slotIdx = {bufChannel, bufOutputDir}; // R3
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bufAddress <= 32'h0000_0000;
    end else if (masterMode) begin
      bufAddress <= bufferBaseAddress + (32'(slotIdx) << `SGC_MASTER_SLOT_AW); // R1 R2
    end else begin
      bufAddress <= 32'(slotIdx) << SLAVE_SHIFT; // R1 R2
    end
  end

  // break sequencer: one channel at a time, lowest first
  assign brkHit = runEn_reg[brkCh_reg] & breakRequest[brkCh_reg];
  assign brkAdvance = (brkState_reg == sgc_pkg::BRK_SCAN && !brkHit)
    || (brkState_reg == sgc_pkg::BRK_HOLD && (msLeft_reg == 8'h00 || !runEn_reg[brkCh_reg]));
  assign brkFinish = brkAdvance && brkCh_reg == 4'(NUM_CH - 1); // R8

  always_ff @(posedge ref_clk) begin
    if (reset || restartReq) begin
      brkState_reg <= sgc_pkg::BRK_IDLE;
      brkCh_reg <= 4'h0;
      msLeft_reg <= 8'h00;
      msDiv_reg <= '0;
      breakSpacing <= '0;
      breakRequestClear <= '0;
    end else begin
      breakRequestClear <= '0;
      case (brkState_reg)
        sgc_pkg::BRK_IDLE: begin
          brkCh_reg <= 4'h0;
          if (brkLaunch) brkState_reg <= sgc_pkg::BRK_SCAN; // R8
        end
        sgc_pkg::BRK_SCAN: begin
          if (brkHit) begin
            breakRequestClear[brkCh_reg] <= 1'b1; // R22
            breakSpacing[brkCh_reg] <= 1'b1; // R21
            msLeft_reg <= breakLengthsMs[brkCh_reg*8 +: 8]; // R21
            msDiv_reg <= '0;
            brkState_reg <= sgc_pkg::BRK_HOLD;
          end else if (brkFinish) begin
            brkState_reg <= sgc_pkg::BRK_IDLE;
          end else begin
            brkCh_reg <= brkCh_reg + 4'h1;
          end
        end
        sgc_pkg::BRK_HOLD: begin
          if (brkAdvance) begin
            breakSpacing[brkCh_reg] <= 1'b0; // R17 R21
            brkCh_reg <= brkCh_reg + 4'h1;
            brkState_reg <= brkFinish ? sgc_pkg::BRK_IDLE : sgc_pkg::BRK_SCAN;
          end else if (msDiv_reg == MSW'(MS_CYCLES - 1)) begin
            msDiv_reg <= '0;
            msLeft_reg <= msLeft_reg - 8'h01; // R21
          end else begin
            msDiv_reg <= msDiv_reg + 1'b1;
          end
        end
        default: brkState_reg <= sgc_pkg::BRK_IDLE;
      endcase
    end
  end

  // self-test sequencer; power-on and restart runs keep the board absent
  assign tstFail = (tstState_reg == sgc_pkg::TST_WAIT) && testDone && !testPass;
  assign tstFinish = tstFail
    || (tstState_reg == sgc_pkg::TST_ISSUE && pending_reg == '0); // R9

  always_ff @(posedge ref_clk) begin
    if (reset || restartReq) begin
      tstState_reg <= sgc_pkg::TST_ISSUE;
      pending_reg <= reset ? `SGC_POR_TESTS : RESTART_TESTS; // R11
      porRun_reg <= 1'b1;
      boardPresent <= 1'b0; // R11
      testInProgress <= 1'b1;
      anyErrorFlag <= 1'b0;
      testFailedFlag <= 1'b0;
      testStart <= 1'b0;
      testIndex <= '0;
    end else begin
      testStart <= 1'b0;
      case (tstState_reg)
        sgc_pkg::TST_IDLE: begin
          if (tstLaunch) begin
            pending_reg <= testProcedureSelect; // R9
            porRun_reg <= 1'b0;
            testInProgress <= 1'b1; // R10
            anyErrorFlag <= 1'b0; // R10
            testFailedFlag <= 1'b0; // R10
            tstState_reg <= sgc_pkg::TST_ISSUE;
          end
        end
        sgc_pkg::TST_ISSUE: begin
          if (tstFinish) begin
            testInProgress <= 1'b0; // R10
            boardPresent <= 1'b1;
            tstState_reg <= sgc_pkg::TST_IDLE;
          end else begin
            testIndex <= topTest(pending_reg); // R9
            testStart <= 1'b1;
            tstState_reg <= sgc_pkg::TST_WAIT;
          end
        end
        sgc_pkg::TST_WAIT: begin
          if (tstFail) begin
            anyErrorFlag <= 1'b1; // R9
            testFailedFlag <= 1'b1;
            testInProgress <= 1'b0;
            boardPresent <= 1'b1;
            tstState_reg <= sgc_pkg::TST_IDLE;
          end else if (testDone) begin
            pending_reg[testIndex] <= 1'b0;
            tstState_reg <= sgc_pkg::TST_ISSUE;
          end
        end
        default: tstState_reg <= sgc_pkg::TST_IDLE;
      endcase
    end
  end

  // led flashes while power-on tests run, else follows the indicator bit
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flashDiv_reg <= '0;
      flash_reg <= 1'b0;
      indicatorLedOn <= 1'b0;
    end else begin
      if (flashDiv_reg == FLW'(FLASH_CYCLES - 1)) begin
        flashDiv_reg <= '0;
        flash_reg <= ~flash_reg;
      end else begin
        flashDiv_reg <= flashDiv_reg + 1'b1;
      end
      indicatorLedOn <= (porRun_reg && tstBusy) ? flash_reg
        : ~mainCmd_reg[`SGC_B_LEDOFF]; // R12
    end
  end

  // arbiter scheme only matters as slot-1 controller
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      arbiterPrioritized <= 1'b0;
    end else begin
      arbiterPrioritized <= sysCtrl & timingCtrl_reg[`SGC_B_ARB]; // R14
    end
  end

  // bus error timer
  assign tmr.timeoutCode = timingCtrl_reg[`SGC_TO_MSB:0];
  assign tmr.sysCtrl = sysCtrl;
  assign tmr.cycleActive = busCycleActive;
  assign tmr.ackSeen = sync2_reg[2];
  assign busError = tmr.busError;

  sgc_bus_timer u_timer (
    .ref_clk(ref_clk),
    .reset(reset),
    .tmr(tmr)
  );

  property p_master_slot;
    @(posedge ref_clk) disable iff (reset)
    masterMode |=> bufAddress == $past(bufferBaseAddress)
      + (32'($past(slotIdx)) << `SGC_MASTER_SLOT_AW);
  endproperty
  a_master_slot: assert property (p_master_slot) // R1 R2 R3
    else $error("master buffer slot address wrong");

  property p_window_capture;
    @(posedge ref_clk) disable iff (reset)
    $rose(mainCmd_reg[`SGC_B_SLVDEC]) |=> slaveWindowBase == $past(bufferBaseAddress);
  endproperty
  a_window_capture: assert property (p_window_capture) // R4
    else $error("window base not captured on enable rise");

  property p_no_decode;
    @(posedge ref_clk) disable iff (reset)
    !mainCmd_reg[`SGC_B_SLVDEC] |=> !bufferSelect;
  endproperty
  a_no_decode: assert property (p_no_decode) // R4
    else $error("buffer selected with decode disabled");

  property p_priv_only;
    @(posedge ref_clk) disable iff (reset)
    mainCmd_reg[`SGC_B_PRIV] && (vmeAm == `SGC_AM_A24_USR || vmeAm == `SGC_AM_A32_USR)
      |=> !bufferSelect;
  endproperty
  a_priv_only: assert property (p_priv_only) // R7
    else $error("user access accepted in privileged-only mode");

  property p_break_start;
    @(posedge ref_clk) disable iff (reset)
    breakRequestClear != '0 |-> $countones(breakRequestClear) == 1
      && (breakSpacing & breakRequestClear) == breakRequestClear
      && $past(breakSpacing) == '0;
  endproperty
  a_break_start: assert property (p_break_start) // R22 R21
    else $error("break request cleared without its break starting");

  property p_launch_held;
    @(posedge ref_clk) disable iff (reset)
    brkBusy && wrMain && !brkFinish && !restartReq |=> mainCmd_reg[`SGC_B_BRK];
  endproperty
  a_launch_held: assert property (p_launch_held) // R23
    else $error("break launch bit dropped while running");

  property p_test_busy;
    @(posedge ref_clk) disable iff (reset)
    tstLaunch && testProcedureSelect != '0 && !restartReq
      |=> testInProgress && !testFailedFlag && !anyErrorFlag ##1 testStart;
  endproperty
  a_test_busy: assert property (p_test_busy) // R9 R10
    else $error("self-test launch not reflected in status");

  property p_go_clears;
    @(posedge ref_clk) disable iff (reset)
    goRise != '0 && !restartReq |=> txRequestClear == $past(goRise)
      && rxAcceptClear == $past(goRise);
  endproperty
  a_go_clears: assert property (p_go_clears) // R19
    else $error("run enable set without clearing tx and rx");

  property p_restart_absent;
    @(posedge ref_clk) disable iff (reset)
    restartReq |=> !boardPresent && testInProgress ##1 !regAck;
  endproperty
  a_restart_absent: assert property (p_restart_absent) // R11
    else $error("board visible during restart tests");

  property p_arbiter;
    @(posedge ref_clk) disable iff (reset)
    !sysCtrl |=> !arbiterPrioritized;
  endproperty
  a_arbiter: assert property (p_arbiter) // R14
    else $error("arbiter scheme applied without controller role");
endmodule
`default_nettype wire

// *** sgc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sgc_host_model (
  input wire logic ref_clk,
  output logic regSelect,
  output logic regWrite,
  output logic [7:0] regAddr,
  output logic [7:0] regWriteData,
  input wire logic [7:0] regReadData,
  input wire logic regAck,
  input wire logic testStart,
  input wire logic failNext,
  output logic testDone,
  output logic testPass
);
  initial begin
    {regSelect, regWrite, regAddr, regWriteData} = '0;
  end
  // request held until the acking edge; no answer in 8 edges means board absent
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic ok);
    @(negedge ref_clk);
    {regSelect, regWrite, regAddr, regWriteData} = {1'b1, w, a, d};
    ok = 0;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge ref_clk);
      ok = regAck;
      q = regReadData;
    end
    @(negedge ref_clk);
    regSelect = 0;
  endtask
  // test engine answers each start three cycles later
  always @(posedge ref_clk) begin
    testDone <= 0;
    if (testStart) begin
      repeat (3) @(posedge ref_clk);
      testDone <= 1;
      testPass <= !failNext;
    end
  end
endmodule
`default_nettype wire

// *** test_serial_ctrl_global_command_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_serial_ctrl_global_command_regs;
  logic ref_clk = 0, reset = 1, failNext = 0, busCycleActive = 0, ok;
  logic vmeValid = 0, bufOutputDir = 0, ackPin = 0, slot1Pin = 1, controllerJumperPin = 1;
  logic regSelect, regWrite, regAck, testStart, testDone, testPass, boardPresent, busError;
  logic masterMode, arbiterPrioritized, testInProgress, anyErrorFlag, testFailedFlag;
  logic indicatorLedOn;
  logic [31:0] bufferBaseAddress = '0, vmeAddr = '0;
  logic [5:0] vmeAm = '0;
  logic [3:0] bufChannel = '0;
  logic [7:0] regAddr, regWriteData, regReadData, q, testProcedureSelect = 8'hff;
  logic [15:0] breakRequest = '0, channelRunEnables, txRequestClear, breakRequestClear;
  logic [15:0] breakSpacing, txSeen = '0, clrSeen = '0, spcSeen = '0;
  logic [2:0] testIndex;
  logic [127:0] breakLengthsMs = '0;
  logic [2:0] idxQ[$];
  int failures = 0, n_checks = 0, spcLen = 0;
  always #12.5 ref_clk = ~ref_clk;
  sgc_global_regs #(.MS_CYCLES(20), .FLASH_CYCLES(8)) uut (.ref_clk, .reset, .regSelect,
    .regWrite, .regAddr, .regWriteData, .regReadData, .regAck, .bufferBaseAddress,
    .testProcedureSelect, .testStart, .testIndex, .testDone, .testPass, .breakRequest,
    .breakRequestClear, .breakLengthsMs, .breakSpacing, .txRequestClear, .rxAcceptClear(),
    .channelRunEnables, .vmeAddr, .vmeAm, .vmeValid, .bufferSelect(), .slaveWindowBase(),
    .bufChannel, .bufOutputDir, .bufAddress(), .masterMode, .slot1Pin, .controllerJumperPin,
    .ackPin, .busCycleActive, .busError, .arbiterPrioritized, .boardPresent, .testInProgress,
    .anyErrorFlag, .testFailedFlag, .indicatorLedOn);
  sgc_host_model host (.ref_clk, .regSelect, .regWrite, .regAddr, .regWriteData,
    .regReadData, .regAck, .testStart, .failNext, .testDone, .testPass);
  // sticky pulse record; break bits behave like the outside register they model
  always @(posedge ref_clk) if (!reset) begin
    txSeen <= txSeen | txRequestClear;
    clrSeen <= clrSeen | breakRequestClear;
    spcSeen <= spcSeen | breakSpacing;
    breakRequest <= breakRequest & ~breakRequestClear;
    if (breakSpacing[15]) spcLen <= spcLen + 1;
    if (testStart) idxQ.push_back(testIndex);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    host.acc(1'b0, a, 8'h00, q, ok);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.acc(1'b1, a, d, q, ok);
  endtask
  // polls main command until the given launch bit drops
  task automatic poll(input int b);
    for (int i = 0; i < 200; i++) begin
      rd(8'h04);
      if (q[b] === 1'b0) break;
    end
  endtask
  task automatic wait_up();
    for (int i = 0; i < 400 && boardPresent !== 1'b1; i++) @(negedge ref_clk);
  endtask
  task automatic t_por();
    wait_up();
    chk(idxQ.size(), 8);
    chk(indicatorLedOn, 0);
    rd(8'h04);
    chk(q, 8'h01);
    rd(8'h05);
    chk(q, 8'h00);
    rd(8'h03);
    chk(q, 8'h00);
    wr(8'h04, 8'h81);
    chk(masterMode, 1);
  endtask
  task automatic t_run_break();
    wr(8'h06, 8'h80);
    wr(8'h07, 8'h01);
    repeat (2) @(negedge ref_clk);
    chk(channelRunEnables, 16'h8001);
    chk(txSeen, 16'h8001);
    breakRequest = 16'h8002;
    breakLengthsMs[127:120] = 8'h02;
    wr(8'h04, 8'h09);
    wr(8'h04, 8'h01);
    rd(8'h04);
    chk(q, 8'h09);
    poll(3);
    chk(q, 8'h01);
    chk(clrSeen, 16'h8000);
    chk(breakRequest, 16'h0002);
    chk(spcSeen, 16'h8000);
    chk(spcLen >= 40 && spcLen <= 42, 1);
  endtask
  // one launched run; the first selected test is the highest mask bit
  task automatic t_test(input logic [7:0] m, input logic f, input int n, input int e);
    testProcedureSelect = m;
    failNext = f;
    idxQ.delete();
    wr(8'h04, 8'h05);
    chk(testInProgress, 1);
    poll(2);
    chk(idxQ.size(), n);
    chk(idxQ[0], e);
    chk({anyErrorFlag, testFailedFlag}, {f, f});
  endtask
  task automatic t_restart();
    failNext = 0;
    idxQ.delete();
    wr(8'h04, 8'h03);
    repeat (2) @(negedge ref_clk);
    chk(boardPresent, 0);
    wait_up();
    chk(idxQ.size(), 7);
    chk(idxQ[0], 6);
    rd(8'h04);
    chk(q, 8'h01);
    vmeValid = 1;
    vmeAm = 6'h39;
    wr(8'h04, 8'h51);
  endtask
  // holds a bus cycle with no acknowledge and looks before and after the limit
  task automatic t_timer(input logic [7:0] v, input int lo, input int hi, input logic e);
    wr(8'h05, v);
    busCycleActive = 1;
    repeat (lo) @(negedge ref_clk);
    chk(busError, 0);
    repeat (hi - lo) @(negedge ref_clk);
    chk(busError, e);
    busCycleActive = 0;
    repeat (4) @(negedge ref_clk);
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    failures++;
    wrap_up();
  end
  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge ref_clk);
    reset = 0;
    t_por();
    t_run_break();
    t_test(8'h05, 1'b0, 2, 2);
    t_test(8'h06, 1'b1, 1, 2);
    t_restart();
    t_timer(8'h08, 150, 190, 1'b1);
    chk(arbiterPrioritized, 1);
    t_timer(8'h06, 20400, 20600, 1'b1);
    slot1Pin = 0;
    t_timer(8'h00, 1950, 2100, 1'b1);
    chk(arbiterPrioritized, 0);
    t_timer(8'h07, 1950, 2100, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
